// File: src/ptw_trigger_waveform.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ptw_trigger_waveform
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire ptw_pkg::ptw_req_type reg_req,
  output logic [31:0] reg_rdata,
  // Time compare and cascade chain
  input wire logic target_reached,
  input wire logic chain_has_tail,
  // Trigger pin and status
  output logic trig_out,
  output logic trig_busy
);
  import ptw_pkg::*;

  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] cycle_width_ff, nxt_cycle_width;
  logic [31:0] count_pattern_ff, nxt_count_pattern;
  logic [15:0] pulse_width_ff, nxt_pulse_width;
  logic trig_unit_enable_ff, nxt_trig_unit_enable;
  logic [31:0] rdata_ff, nxt_rdata;
  ptw_state_type state_ff, nxt_state;
  ptw_cfg_type cfg_ff, nxt_cfg;
  logic [32:0] elapsed_ff, nxt_elapsed;
  logic [15:0] cycles_ff, nxt_cycles;
  logic [15:0] iters_ff, nxt_iters;
  logic [3:0] bit_idx_ff, nxt_bit_idx;
  logic out_ff, nxt_out;
  logic busy_ff, nxt_busy;
  logic fire;
  logic [32:0] step_sum;
  logic [32:0] pulse_ns;
  logic [32:0] cycle_ns;
  logic [32:0] end_ns;
  logic slot_end;
  logic [2:0] sel_shape;

  // Idle level of each shape; active level is its inverse
  function automatic logic idle_level(input logic [2:0] shape);
    idle_level = (shape == PTW_FALL_EDGE) || (shape == PTW_NEG_PULSE)
      || (shape == PTW_NEG_PERIOD);
  endfunction : idle_level

  assign sel_shape = ctrl_ff[PTW_SHAPE_LSB +: 3];
  assign fire = trig_unit_enable_ff && target_reached && (state_ff == PTW_ST_IDLE)
    && (sel_shape != PTW_RESERVED);
  assign pulse_ns = {17'h0, cfg_ff.pulse_width} << PTW_PULSE_SHIFT;
  assign cycle_ns = {1'b0, cfg_ff.cycle_width};
  assign step_sum = elapsed_ff + PTW_STEP_NS;
  assign end_ns = ((cfg_ff.shape == PTW_NEG_PULSE) || (cfg_ff.shape == PTW_POS_PULSE))
    ? pulse_ns : cycle_ns;
  assign slot_end = step_sum >= end_ns;

  // Register writes and one-cycle-late read data
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_cycle_width = cycle_width_ff;
    nxt_count_pattern = count_pattern_ff;
    nxt_pulse_width = pulse_width_ff;
    nxt_trig_unit_enable = trig_unit_enable_ff;
    nxt_rdata = 32'h0000_0000;
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        PTW_ADDR_CTRL: nxt_ctrl = reg_req.wdata & 32'hCCF0_FFFF;
        PTW_ADDR_CYCLE_WIDTH: nxt_cycle_width = reg_req.wdata;
        PTW_ADDR_COUNT_PATTERN: nxt_count_pattern = reg_req.wdata;
        PTW_ADDR_PULSE_WIDTH: nxt_pulse_width = reg_req.wdata[15:0];
        PTW_ADDR_ENABLE_STATUS: nxt_trig_unit_enable = reg_req.wdata[PTW_ENABLE_BIT];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        PTW_ADDR_CTRL: nxt_rdata = ctrl_ff;
        PTW_ADDR_CYCLE_WIDTH: nxt_rdata = cycle_width_ff;
        PTW_ADDR_COUNT_PATTERN: nxt_rdata = count_pattern_ff;
        PTW_ADDR_PULSE_WIDTH: nxt_rdata = {16'h0000, pulse_width_ff};
        PTW_ADDR_ENABLE_STATUS:
        begin
          nxt_rdata[PTW_ENABLE_BIT] = trig_unit_enable_ff;
          nxt_rdata[PTW_BUSY_BIT] = busy_ff;
          nxt_rdata[PTW_DONE_BIT] = (state_ff == PTW_ST_DONE);
          nxt_rdata[PTW_LEVEL_BIT] = out_ff;
        end
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_ff <= PTW_CTRL_RESET;
      cycle_width_ff <= 32'h0000_0000;
      count_pattern_ff <= 32'h0000_0000;
      pulse_width_ff <= 16'h0000;
      trig_unit_enable_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      cycle_width_ff <= nxt_cycle_width;
      count_pattern_ff <= nxt_count_pattern;
      pulse_width_ff <= nxt_pulse_width;
      trig_unit_enable_ff <= nxt_trig_unit_enable;
      rdata_ff <= nxt_rdata;
    end
  end

  // Waveform sequencer: time kept in ns, advanced one clock period per edge
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cfg = cfg_ff;
    nxt_elapsed = elapsed_ff;
    nxt_cycles = cycles_ff;
    nxt_iters = iters_ff;
    nxt_bit_idx = bit_idx_ff;
    nxt_out = out_ff;
    unique case (state_ff)
      PTW_ST_IDLE:
      begin
        nxt_out = idle_level(sel_shape);
        if (fire)
        begin
          // Snapshot of all settings for the whole waveform
          nxt_cfg = '{shape: sel_shape, pulse_width: pulse_width_ff,
            cycle_width: cycle_width_ff,
            cycle_count: count_pattern_ff[PTW_CNT_LSB +: 16],
            pattern: count_pattern_ff[PTW_PAT_LSB +: 16],
            iteration: ctrl_ff[PTW_ITER_LSB +: 16],
            cascade: ctrl_ff[PTW_CASCADE_BIT], tail: ctrl_ff[PTW_TAIL_BIT]};
          nxt_elapsed = 33'h0_0000_0000;
          nxt_bit_idx = PTW_TOP_BIT;
          unique case (sel_shape)
            PTW_FALL_EDGE:
            begin
              nxt_out = 1'b0;
              nxt_state = PTW_ST_DONE;
            end
            PTW_RISE_EDGE:
            begin
              nxt_out = 1'b1;
              nxt_state = PTW_ST_DONE;
            end
            PTW_PATTERN:
            begin
              nxt_out = count_pattern_ff[PTW_PAT_LSB + 15];
              nxt_state = PTW_ST_RUN;
            end
            default:
            begin
              nxt_out = ~idle_level(sel_shape);
              nxt_state = PTW_ST_RUN;
            end
          endcase
        end
      end
      PTW_ST_RUN:
      begin
        nxt_elapsed = slot_end ? step_sum - end_ns : step_sum;
        unique case (cfg_ff.shape)
          PTW_NEG_PULSE, PTW_POS_PULSE:
          begin
            if (slot_end)
            begin
              nxt_out = idle_level(cfg_ff.shape);
              nxt_state = PTW_ST_DONE;
            end
          end
          PTW_NEG_PERIOD, PTW_POS_PERIOD:
          begin
            // Active phase first, then idle phase until cycle end
            nxt_out = (nxt_elapsed < pulse_ns) ? ~idle_level(cfg_ff.shape)
              : idle_level(cfg_ff.shape);
            if (slot_end)
            begin
              nxt_cycles = cycles_ff + 16'h0001;
              if ((cfg_ff.cycle_count != 16'h0000) && (nxt_cycles == cfg_ff.cycle_count))
              begin
                nxt_out = idle_level(cfg_ff.shape);
                nxt_state = PTW_ST_DONE;
              end
            end
          end
          default:
          begin
            if (slot_end)
            begin
              nxt_bit_idx = bit_idx_ff - 4'h1;
              nxt_cycles = cycles_ff + 16'h0001;
              if (bit_idx_ff == 4'h0)
              begin
                nxt_iters = iters_ff + 16'h0001;
              end
              nxt_out = cfg_ff.pattern[nxt_bit_idx];
              if (cfg_ff.cascade)
              begin
                // Iteration count only matters for a tail in a chain with one
                if (cfg_ff.tail && chain_has_tail && (bit_idx_ff == 4'h0)
                  && (iters_ff == cfg_ff.iteration))
                begin
                  nxt_out = idle_level(cfg_ff.shape);
                  nxt_state = PTW_ST_DONE;
                end
              end
              else if ((cfg_ff.cycle_count != 16'h0000)
                && (nxt_cycles == cfg_ff.cycle_count))
              begin
                nxt_out = idle_level(cfg_ff.shape);
                nxt_state = PTW_ST_DONE;
              end
            end
          end
        endcase
      end
      PTW_ST_DONE: nxt_out = out_ff;
    endcase
    // Disable aborts and clears state, time, counters and bit index, and sets the output to the idle level
    if (!trig_unit_enable_ff)
    begin
      nxt_state = PTW_ST_IDLE;
      nxt_elapsed = 33'h0_0000_0000;
      nxt_cycles = 16'h0000;
      nxt_iters = 16'h0000;
      nxt_bit_idx = PTW_TOP_BIT;
      nxt_out = idle_level(sel_shape);
    end
    nxt_busy = (nxt_state == PTW_ST_RUN);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= PTW_ST_IDLE;
      cfg_ff <= '0;
      elapsed_ff <= 33'h0_0000_0000;
      cycles_ff <= 16'h0000;
      iters_ff <= 16'h0000;
      bit_idx_ff <= PTW_TOP_BIT;
      out_ff <= 1'b1;
      busy_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cfg_ff <= nxt_cfg;
      elapsed_ff <= nxt_elapsed;
      cycles_ff <= nxt_cycles;
      iters_ff <= nxt_iters;
      bit_idx_ff <= nxt_bit_idx;
      out_ff <= nxt_out;
      busy_ff <= nxt_busy;
    end
  end
  assign reg_rdata = rdata_ff;
  assign trig_out = out_ff;
  assign trig_busy = busy_ff;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  property p_reserved_blocks;
    trig_unit_enable_ff && target_reached && sel_shape == PTW_RESERVED
      && state_ff == PTW_ST_IDLE |=> state_ff == PTW_ST_IDLE;
  endproperty
  a_reserved_blocks: assert property (p_reserved_blocks)
    else $error("reserved shape started a waveform");
  property p_fall_edge;
    fire && sel_shape == PTW_FALL_EDGE && $past(trig_unit_enable_ff)
      |=> !trig_out ##1 (!trig_out || !trig_unit_enable_ff);
  endproperty
  a_fall_edge: assert property (p_fall_edge)
    else $error("falling edge shape did not go and stay low");
  property p_rise_edge;
    fire && sel_shape == PTW_RISE_EDGE |=> trig_out && state_ff == PTW_ST_DONE;
  endproperty
  a_rise_edge: assert property (p_rise_edge)
    else $error("rising edge shape did not go high");
  property p_neg_pulse;
    fire && sel_shape == PTW_NEG_PULSE |=> !trig_out && trig_busy;
  endproperty
  a_neg_pulse: assert property (p_neg_pulse)
    else $error("negative pulse did not start low");
  property p_pos_pulse;
    fire && sel_shape == PTW_POS_PULSE |=> trig_out && trig_busy;
  endproperty
  a_pos_pulse: assert property (p_pos_pulse)
    else $error("positive pulse did not start high");
  property p_disabled_clear;
    !trig_unit_enable_ff |=> state_ff == PTW_ST_IDLE && cycles_ff == 16'h0000
      && iters_ff == 16'h0000 && !trig_busy;
  endproperty
  a_disabled_clear: assert property (p_disabled_clear)
    else $error("disabled unit kept running or counting");
  property p_reserved_zero;
    reg_req.rd && reg_req.addr == PTW_ADDR_CTRL |=> reg_rdata[19:16] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bits read nonzero");
  property p_cfg_held;
    trig_busy && $past(trig_busy) |-> $stable(cfg_ff);
  endproperty
  a_cfg_held: assert property (p_cfg_held)
    else $error("settings changed during waveform");
  property p_pulse_len;
    (fire && sel_shape == PTW_POS_PULSE && pulse_width_ff == 16'h0019)
      ##1 trig_unit_enable_ff [*2] |-> trig_out ##1 !trig_out;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("200 ns pulse did not last two clocks");
endmodule : ptw_trigger_waveform
`default_nettype wire

// File: src/ptw_pkg.sv
package ptw_pkg;
  // Register offsets, byte addresses on the plain register port
  localparam logic [7:0] PTW_ADDR_CTRL = 8'h00;
  localparam logic [7:0] PTW_ADDR_CYCLE_WIDTH = 8'h04;
  localparam logic [7:0] PTW_ADDR_COUNT_PATTERN = 8'h08;
  localparam logic [7:0] PTW_ADDR_PULSE_WIDTH = 8'h0C;
  localparam logic [7:0] PTW_ADDR_ENABLE_STATUS = 8'h10;
  // Register field positions: control, count/pattern and enable/status
  localparam int PTW_CASCADE_BIT = 31;
  localparam int PTW_TAIL_BIT = 30;
  localparam int PTW_SHAPE_LSB = 20;
  localparam int PTW_ITER_LSB = 0;
  localparam int PTW_CNT_LSB = 16;
  localparam int PTW_PAT_LSB = 0;
  localparam int PTW_ENABLE_BIT = 0;
  localparam int PTW_BUSY_BIT = 8;
  localparam int PTW_DONE_BIT = 9;
  localparam int PTW_LEVEL_BIT = 10;
  // Reset values
  localparam logic [31:0] PTW_CTRL_RESET = 32'h0000_0000;
  localparam logic [2:0] PTW_SHAPE_RESET = 3'h0;
  // Timing: clock period and setting units, in ns
  localparam int PTW_CLK_NS = 100;
  localparam int PTW_PULSE_UNIT_NS = 8;
  localparam int PTW_CYCLE_UNIT_NS = 1;
  localparam int PTW_PULSE_SHIFT = $clog2(PTW_PULSE_UNIT_NS);
  localparam logic [32:0] PTW_STEP_NS = 33'(PTW_CLK_NS);
  localparam logic [3:0] PTW_TOP_BIT = 4'hF;
  // Output shapes
  localparam logic [2:0] PTW_FALL_EDGE = 3'h0;
  localparam logic [2:0] PTW_RISE_EDGE = 3'h1;
  localparam logic [2:0] PTW_NEG_PULSE = 3'h2;
  localparam logic [2:0] PTW_POS_PULSE = 3'h3;
  localparam logic [2:0] PTW_NEG_PERIOD = 3'h4;
  localparam logic [2:0] PTW_POS_PERIOD = 3'h5;
  localparam logic [2:0] PTW_PATTERN = 3'h6;
  localparam logic [2:0] PTW_RESERVED = 3'h7;

  typedef enum logic [1:0] {PTW_ST_IDLE, PTW_ST_RUN, PTW_ST_DONE} ptw_state_type;

  // Waveform settings, latched when the trigger fires
  typedef struct packed {
    logic [2:0] shape;
    logic [15:0] pulse_width;
    logic [31:0] cycle_width;
    logic [15:0] cycle_count;
    logic [15:0] pattern;
    logic [15:0] iteration;
    logic cascade;
    logic tail;
  } ptw_cfg_type;

  // Plain register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ptw_req_type;
endpackage : ptw_pkg

// File: test/ptw_pin_sampler.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side logic that samples the trigger pin once per clock
module ptw_pin_sampler
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Control and pin
  input wire logic clear,
  input wire logic trig_out,
  // Observed counts
  output logic [15:0] hi_cnt,
  output logic [15:0] lo_cnt,
  output logic [15:0] rise_cnt,
  output logic [15:0] fall_cnt
);
  logic prev_ff;

  // Level and edge counting, restarted by clear
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {hi_cnt, lo_cnt, rise_cnt, fall_cnt} <= '0;
      prev_ff <= 1'b1;
    end
    else if (clear)
    begin
      {hi_cnt, lo_cnt, rise_cnt, fall_cnt} <= '0;
      prev_ff <= trig_out;
    end
    else
    begin
      hi_cnt <= hi_cnt + 16'(trig_out);
      lo_cnt <= lo_cnt + 16'(!trig_out);
      rise_cnt <= rise_cnt + 16'(trig_out && !prev_ff);
      fall_cnt <= fall_cnt + 16'(!trig_out && prev_ff);
      prev_ff <= trig_out;
    end
  end
endmodule : ptw_pin_sampler
`default_nettype wire

// File: test/ptw_trigger_waveform_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ptw_trigger_waveform_select_tb;
  import ptw_pkg::*;
  typedef struct packed {logic [3:0] id; logic [31:0] exp;} ptw_note_type;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  ptw_req_type req = '0;
  logic target_reached = 1'b0;
  logic chain_has_tail = 1'b1;
  logic clear = 1'b1;
  logic pin_chk = 1'b0;
  logic rd_q = 1'b0;
  logic chk_q = 1'b0;
  logic [31:0] reg_rdata;
  logic trig_out;
  logic trig_busy;
  logic [15:0] hi_cnt, lo_cnt, rise_cnt, fall_cnt;
  logic [31:0] seed = 32'h48099F6F;
  int fails = 0;
  int checked = 0;
  ptw_note_type notes[$];
  string item_names[10] = '{"trig_out", "hi_cnt", "lo_cnt", "rise_cnt", "fall_cnt",
    "trig_busy", "reg_rdata", "reg_rdata", "reg_rdata", "reg_rdata"};
  // Expected per shape: idle level, final level, edges, active cycles
  logic [0:7] idle_tab = 8'hA8;
  logic [0:7] final_tab = 8'h68;
  int rise_tab[8] = '{0, 1, 1, 1, 3, 3, 2, 0};
  int fall_tab[8] = '{1, 0, 1, 1, 3, 3, 2, 0};
  int act_tab[8] = '{-1, -1, 2, 2, 6, 6, 8, 0};

  ptw_trigger_waveform u_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_req(req),
    .reg_rdata(reg_rdata), .target_reached(target_reached), .chain_has_tail(chain_has_tail),
    .trig_out(trig_out), .trig_busy(trig_busy));
  ptw_pin_sampler u_pin (.sys_clk(sys_clk), .rstn(rstn), .clear(clear), .trig_out(trig_out),
    .hi_cnt(hi_cnt), .lo_cnt(lo_cnt), .rise_cnt(rise_cnt), .fall_cnt(fall_cnt));

  // Clock
  always #50 sys_clk = ~sys_clk;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xorshift

  task automatic end_sim();
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    notes.push_back({4'h9, e});
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge sys_clk);
    req.rd <= 1'b0;
  endtask : rd_reg

  // Note an expected observation, sampled after the next edge
  task automatic expect_val(input logic [3:0] id, input logic [31:0] e);
    @(posedge sys_clk);
    notes.push_back({id, e});
    pin_chk <= 1'b1;
    @(posedge sys_clk);
    pin_chk <= 1'b0;
  endtask : expect_val

  // Result watcher: takes the oldest note when a result appears
  always @(posedge sys_clk)
  begin
    rd_q <= req.rd;
    chk_q <= pin_chk;
  end
  always @(negedge sys_clk)
  begin
    ptw_note_type n;
    logic [31:0] obs;
    if ((rd_q || chk_q) && notes.size() > 0)
    begin
      n = notes.pop_front();
      case (n.id)
        4'h0: obs = {31'h0, trig_out};
        4'h1: obs = {16'h0, hi_cnt};
        4'h2: obs = {16'h0, lo_cnt};
        4'h3: obs = {16'h0, rise_cnt};
        4'h4: obs = {16'h0, fall_cnt};
        4'h5: obs = {31'h0, trig_busy};
        default: obs = reg_rdata;
      endcase
      checked++;
      if (obs !== n.exp)
      begin
        fails++;
        $display("BAD %s expected %h seen %h", item_names[n.id], n.exp, obs);
      end
    end
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    logic [31:0] it;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    rd_reg(PTW_ADDR_CTRL, 32'h0000_0000);
    rd_reg(PTW_ADDR_ENABLE_STATUS, 32'h0000_0400);
    wr_reg(PTW_ADDR_CTRL, 32'hFFFF_FFFF);
    rd_reg(PTW_ADDR_CTRL, 32'hCCF0_FFFF);
    rd_reg(8'h14, 32'h0000_0000);
    // Every shape: 200 ns pulse, 400 ns cycle, three cycles or bits
    for (int s = 0; s < 8; s++)
    begin
      wr_reg(PTW_ADDR_CTRL, 32'(s) << PTW_SHAPE_LSB);
      wr_reg(PTW_ADDR_CYCLE_WIDTH, 32'h0000_0190);
      wr_reg(PTW_ADDR_COUNT_PATTERN, 32'h0003_A000);
      wr_reg(PTW_ADDR_PULSE_WIDTH, 32'h0000_0019);
      clear <= 1'b0;
      wr_reg(PTW_ADDR_ENABLE_STATUS, 32'h0000_0001);
      repeat (4) @(posedge sys_clk);
      expect_val(4'h3, 32'h0);
      target_reached <= 1'b1;
      wr_reg(PTW_ADDR_PULSE_WIDTH, 32'h0000_00FF);
      repeat (30) @(posedge sys_clk);
      expect_val(4'h0, {31'h0, final_tab[s]});
      expect_val(4'h3, 32'(rise_tab[s]));
      expect_val(4'h4, 32'(fall_tab[s]));
      if (act_tab[s] >= 0)
        expect_val(idle_tab[s] ? 4'h2 : 4'h1, 32'(act_tab[s]));
      wr_reg(PTW_ADDR_ENABLE_STATUS, 32'h0000_0000);
      target_reached <= 1'b0;
      repeat (2) @(posedge sys_clk);
      expect_val(4'h0, {31'h0, idle_tab[s]});
      clear <= 1'b1;
    end
    // Cascade tail unit with a random iteration count
    seed = xorshift(seed);
    it = seed % 3;
    wr_reg(PTW_ADDR_CTRL, 32'hC060_0000 | it);
    wr_reg(PTW_ADDR_COUNT_PATTERN, 32'h0000_8001);
    clear <= 1'b0;
    wr_reg(PTW_ADDR_ENABLE_STATUS, 32'h0000_0001);
    target_reached <= 1'b1;
    repeat (66 * (it + 1)) @(posedge sys_clk);
    expect_val(4'h1, 32'h8 * (it + 1));
    expect_val(4'h5, 32'h0);
    wr_reg(PTW_ADDR_ENABLE_STATUS, 32'h0000_0000);
    target_reached <= 1'b0;
    clear <= 1'b1;
    // No tail in the chain: pattern never stops
    chain_has_tail <= 1'b0;
    wr_reg(PTW_ADDR_CTRL, 32'hC060_0000);
    wr_reg(PTW_ADDR_ENABLE_STATUS, 32'h0000_0001);
    target_reached <= 1'b1;
    repeat (150) @(posedge sys_clk);
    expect_val(4'h5, 32'h1);
    wr_reg(PTW_ADDR_ENABLE_STATUS, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    expect_val(4'h5, 32'h0);
    repeat (3) @(posedge sys_clk);
    end_sim();
  end
endmodule : ptw_trigger_waveform_select_tb
`default_nettype wire
